// ==== src/irqre_consts.svh ====
// Constants for the interrupt request and enable logic
`ifndef IRQRE_CONSTS_SVH
`define IRQRE_CONSTS_SVH
`define IRQRE_ADDR_W 6
`define IRQRE_OFS_COMM_EN 6'h02
`define IRQRE_OFS_MISC_EN 6'h03
`define IRQRE_OFS_COMM_RQ 6'h04
`define IRQRE_OFS_MISC_RQ 6'h05
`define IRQRE_RST_COMM_EN 8'h80
`define IRQRE_RST_MISC_EN 8'h00
`define IRQRE_RST_COMM_RQ 7'h14
`define IRQRE_RST_MISC_RQ 5'h00
`define IRQRE_SET_SEL_BIT 7
`define IRQRE_PUSH_PULL_BIT 7
`define IRQRE_INVERT_BIT 7
`define IRQRE_MISC_EN_MASK 8'h9F
`define IRQRE_B_TX 6
`define IRQRE_B_RX 5
`define IRQRE_B_IDLE 4
`define IRQRE_B_HI 3
`define IRQRE_B_LO 2
`define IRQRE_B_ERR 1
`define IRQRE_B_TMR 0
`define IRQRE_B_SIG 4
`define IRQRE_B_MODE 3
`define IRQRE_B_CRC 2
`define IRQRE_B_FON 1
`define IRQRE_B_FOFF 0
`define IRQRE_CMD_IDLE 4'h0
`define IRQRE_CMD_AUTO_ANTICOLLISION_COMMAND 4'hD
`define IRQRE_CMD_KNOWN 16'hFFFF
`define IRQRE_PIN_SIG 0
`define IRQRE_PIN_FIELD 1
`endif

// ==== src/irqre_pkg.sv ====
// Types for the interrupt request and enable logic
package irqre_pkg;
  typedef logic [7:0] irqre_byte_t;
  typedef enum logic [0:0] {
    IRQRE_DET_STOP = 1'b0,
    IRQRE_DET_RUN = 1'b1
  } irqre_det_e;
endpackage : irqre_pkg

// ==== src/irqre_pin_if.sv ====
// Carrier between pin synchroniser and request logic
`timescale 1ns/1ps
interface irqre_pin_if;
  logic [1:0] raw;
  logic [1:0] lvl;
  logic [1:0] edg;
  modport sync_mp (input raw, output lvl, output edg);
  modport use_mp (output raw, input lvl, input edg);
endinterface : irqre_pin_if

// ==== src/irqre_pin_sync.sv ====
// Three-stage pin synchroniser with edge detect
`timescale 1ns/1ps
module irqre_pin_sync
  import irqre_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  irqre_pin_if.sync_mp pins
);
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      logic s1_r;
      logic s2_r;
      logic s3_r;
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
        end else if (ce_i) begin
          s1_r <= pins.raw[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end
      // Agreed level and one-cycle change pulse
      assign pins.lvl[g] = s3_r;
      assign pins.edg[g] = ce_i & (s2_r ^ s3_r);
    end
  endgenerate
endmodule : irqre_pin_sync

// ==== src/irqre_top.sv ====
// Interrupt request and enable logic
`timescale 1ns/1ps
`include "irqre_consts.svh"
module irqre_top
  import irqre_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic tx_last_bit_i,
  input wire logic rx_end_valid_i,
  input wire logic receive_requires_data_option_i,
  input wire logic fifo_has_data_i,
  input wire logic fifo_high_status_i,
  input wire logic fifo_low_status_i,
  input wire logic [7:0] error_bits_i,
  input wire logic countdown_zero_i,
  input wire logic [3:0] cmd_code_i,
  input wire logic host_cmd_wr_i,
  input wire logic [3:0] host_cmd_code_i,
  output logic cmd_revert_idle_o,
  input wire logic checksum_cmd_active_i,
  input wire logic checksum_all_done_i,
  input wire logic mode_found_i,
  input wire logic rf_reset_i,
  output logic mode_detect_run_o,
  input wire logic secure_signal_input_i,
  input wire logic field_present_i,
  output logic irq_status_o,
  output logic irq_pin_o,
  output logic irq_pin_oe_o
);
  irqre_byte_t comm_irq_enable_r;
  irqre_byte_t misc_irq_enable_r;
  logic [6:0] comm_rq_r;
  logic [6:0] comm_rq_nxt;
  logic [4:0] misc_rq_r;
  logic [4:0] misc_rq_nxt;
  logic [6:0] comm_hw_set;
  logic [4:0] misc_hw_set;
  logic [6:0] comm_sw_set;
  logic [6:0] comm_sw_clr;
  logic [4:0] misc_sw_set;
  logic [4:0] misc_sw_clr;
  logic fifo_high_d_r;
  logic fifo_low_d_r;
  logic [3:0] cmd_prev_r;
  logic idle_by_host_r;
  logic host_idle_now;
  logic cmd_unknown;
  logic [15:0] cmd_known;
  logic cmd_end_seen;
  irqre_det_e det_state_r;
  irqre_det_e det_state_nxt;
  logic wr_comm_en;
  logic wr_misc_en;
  logic wr_comm_rq;
  logic wr_misc_rq;
  logic irq_any;
  logic pin_level;
  irqre_pin_if pin_bus ();

  assign pin_bus.raw[`IRQRE_PIN_SIG] = secure_signal_input_i;
  assign pin_bus.raw[`IRQRE_PIN_FIELD] = field_present_i;

  irqre_pin_sync u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pins(pin_bus.sync_mp)
  );

  // Register write decode
  assign wr_comm_en = ce_i & reg_wr_i & (reg_addr_i == `IRQRE_OFS_COMM_EN);
  assign wr_misc_en = ce_i & reg_wr_i & (reg_addr_i == `IRQRE_OFS_MISC_EN);
  assign wr_comm_rq = ce_i & reg_wr_i & (reg_addr_i == `IRQRE_OFS_COMM_RQ);
  assign wr_misc_rq = ce_i & reg_wr_i & (reg_addr_i == `IRQRE_OFS_MISC_RQ);

  // Enable registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      comm_irq_enable_r <= `IRQRE_RST_COMM_EN;
    end else if (wr_comm_en) begin
      comm_irq_enable_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      misc_irq_enable_r <= `IRQRE_RST_MISC_EN;
    end else if (wr_misc_en) begin
      misc_irq_enable_r <= reg_wdata_i & `IRQRE_MISC_EN_MASK;
    end
  end

  // Software set and clear masks
  always_comb begin
    comm_sw_set = '0;
    comm_sw_clr = '0;
    if (wr_comm_rq) begin
      if (reg_wdata_i[`IRQRE_SET_SEL_BIT]) begin
        comm_sw_set = reg_wdata_i[6:0];
      end else begin
        comm_sw_clr = reg_wdata_i[6:0];
      end
    end
  end

  always_comb begin
    misc_sw_set = '0;
    misc_sw_clr = '0;
    if (wr_misc_rq) begin
      if (reg_wdata_i[`IRQRE_SET_SEL_BIT]) begin
        misc_sw_set = reg_wdata_i[4:0];
      end else begin
        misc_sw_clr = reg_wdata_i[4:0];
      end
    end
  end

  // Command tracking
  assign host_idle_now = host_cmd_wr_i & (host_cmd_code_i == `IRQRE_CMD_IDLE);
  assign cmd_known = `IRQRE_CMD_KNOWN;
  assign cmd_unknown = host_cmd_wr_i & ~cmd_known[host_cmd_code_i];
  assign cmd_revert_idle_o = ce_i & cmd_unknown;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_prev_r <= `IRQRE_CMD_IDLE;
      idle_by_host_r <= 1'b0;
    end else if (ce_i) begin
      cmd_prev_r <= cmd_code_i;
      idle_by_host_r <= host_idle_now;
    end
  end

  // Self-ended command, excluding a host-issued idle
  assign cmd_end_seen = (cmd_prev_r != `IRQRE_CMD_IDLE) &
                        (cmd_code_i == `IRQRE_CMD_IDLE) &
                        ~host_idle_now & ~idle_by_host_r;

  // FIFO alert rise detect
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fifo_high_d_r <= 1'b0;
      fifo_low_d_r <= 1'b0;
    end else if (ce_i) begin
      fifo_high_d_r <= fifo_high_status_i;
      fifo_low_d_r <= fifo_low_status_i;
    end
  end

  // Hardware events, communication group
  always_comb begin
    comm_hw_set = '0;
    comm_hw_set[`IRQRE_B_TX] = tx_last_bit_i;
    comm_hw_set[`IRQRE_B_RX] = rx_end_valid_i &
      (~receive_requires_data_option_i | fifo_has_data_i);
    comm_hw_set[`IRQRE_B_IDLE] = cmd_end_seen | cmd_unknown;
    comm_hw_set[`IRQRE_B_HI] = fifo_high_status_i & ~fifo_high_d_r;
    comm_hw_set[`IRQRE_B_LO] = fifo_low_status_i & ~fifo_low_d_r;
    comm_hw_set[`IRQRE_B_ERR] = |error_bits_i;
    comm_hw_set[`IRQRE_B_TMR] = countdown_zero_i;
  end

  // Data mode detector
  always_comb begin
    det_state_nxt = det_state_r;
    case (det_state_r)
      IRQRE_DET_STOP: begin
        if ((host_cmd_wr_i & (host_cmd_code_i == `IRQRE_CMD_AUTO_ANTICOLLISION_COMMAND)) | rf_reset_i) begin
          det_state_nxt = IRQRE_DET_RUN;
        end
      end
      IRQRE_DET_RUN: begin
        if (mode_found_i & ~rf_reset_i) begin
          det_state_nxt = IRQRE_DET_STOP;
        end
      end
      default: begin
        det_state_nxt = IRQRE_DET_STOP;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      det_state_r <= IRQRE_DET_STOP;
    end else if (ce_i) begin
      det_state_r <= det_state_nxt;
    end
  end

  assign mode_detect_run_o = (det_state_r == IRQRE_DET_RUN);

  // Hardware events, misc group
  always_comb begin
    misc_hw_set = '0;
    misc_hw_set[`IRQRE_B_SIG] = pin_bus.edg[`IRQRE_PIN_SIG];
    misc_hw_set[`IRQRE_B_MODE] = mode_detect_run_o & mode_found_i;
    misc_hw_set[`IRQRE_B_CRC] = checksum_cmd_active_i & checksum_all_done_i;
    // Level still shows the old value while the change pulse stands
    misc_hw_set[`IRQRE_B_FON] = pin_bus.edg[`IRQRE_PIN_FIELD] &
                                ~pin_bus.lvl[`IRQRE_PIN_FIELD];
    misc_hw_set[`IRQRE_B_FOFF] = pin_bus.edg[`IRQRE_PIN_FIELD] &
                                 pin_bus.lvl[`IRQRE_PIN_FIELD];
  end

  // Latched requests; a hardware set beats a clear
  assign comm_rq_nxt = (comm_rq_r & ~comm_sw_clr) | comm_sw_set | comm_hw_set;
  assign misc_rq_nxt = (misc_rq_r & ~misc_sw_clr) | misc_sw_set | misc_hw_set;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      comm_rq_r <= `IRQRE_RST_COMM_RQ;
    end else if (ce_i) begin
      comm_rq_r <= comm_rq_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      misc_rq_r <= `IRQRE_RST_MISC_RQ;
    end else if (ce_i) begin
      misc_rq_r <= misc_rq_nxt;
    end
  end

  // Combined status from enabled requests
  assign irq_any = |(comm_rq_r & comm_irq_enable_r[6:0]) |
                   |(misc_rq_r & misc_irq_enable_r[4:0]);
  assign pin_level = irq_any ^ comm_irq_enable_r[`IRQRE_INVERT_BIT];

  // Registered status and pin drive
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status_o <= 1'b0;
      irq_pin_o <= 1'b0;
      irq_pin_oe_o <= 1'b0;
    end else if (ce_i) begin
      irq_status_o <= irq_any;
      if (misc_irq_enable_r[`IRQRE_PUSH_PULL_BIT]) begin
        irq_pin_o <= pin_level;
        irq_pin_oe_o <= 1'b1;
      end else begin
        irq_pin_o <= 1'b0;
        irq_pin_oe_o <= ~pin_level;
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i & reg_rd_i) begin
      case (reg_addr_i)
        `IRQRE_OFS_COMM_EN: reg_rdata_o <= comm_irq_enable_r;
        `IRQRE_OFS_MISC_EN: reg_rdata_o <= misc_irq_enable_r;
        `IRQRE_OFS_COMM_RQ: reg_rdata_o <= {1'b0, comm_rq_r};
        `IRQRE_OFS_MISC_RQ: reg_rdata_o <= {3'b000, misc_rq_r};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule : irqre_top

// ==== tb/irqre_host_model.sv ====
// Host side model: resolves the interrupt wire it watches
`timescale 1ns/1ps
module irqre_host_model (
  input wire logic pin_i,
  input wire logic oe_i,
  output logic wire_o
);
  // Board pull-up holds the line high once released
  assign wire_o = oe_i ? pin_i : 1'h1;
endmodule : irqre_host_model

// ==== tb/irqre_top_props.sv ====
// Checker for the interrupt request and enable logic
`timescale 1ns/1ps
module irqre_top_props (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic tx_last_bit_i,
  input wire logic [7:0] error_bits_i,
  input wire logic countdown_zero_i,
  input wire logic irq_status_o,
  input wire logic irq_pin_o,
  input wire logic irq_pin_oe_o
);
  logic pp_r;
  logic inv_r;
  wire wr_ok = ce_i && reg_wr_i;
  wire rd4 = ce_i && reg_rd_i && reg_addr_i == 6'h04;
  // Shadow of driver type and invert bits
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pp_r <= 1'h0;
      inv_r <= 1'h1;
    end else if (wr_ok && reg_addr_i == 6'h03) begin
      pp_r <= reg_wdata_i[7];
    end else if (wr_ok && reg_addr_i == 6'h02) begin
      inv_r <= reg_wdata_i[7];
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  push_pull_a: assert property (pp_r && $stable(pp_r) && $stable(inv_r) |->
    irq_pin_oe_o && irq_pin_o == (irq_status_o ^ inv_r)) else $error("push-pull pin wrong");
  open_drain_a: assert property (!pp_r && $stable(pp_r) && $stable(inv_r) |->
    !irq_pin_o && irq_pin_oe_o == !(irq_status_o ^ inv_r)) else $error("open-drain pin wrong");
  unmapped_read_a: assert property (ce_i && reg_rd_i && (reg_addr_i < 6'h02 || reg_addr_i > 6'h05)
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  select_bit_a: assert property (ce_i && reg_rd_i && reg_addr_i inside {6'h04, 6'h05}
    |=> !reg_rdata_o[7]) else $error("select bit reads one");
  reserved_bits_a: assert property (ce_i && reg_rd_i && reg_addr_i inside {6'h03, 6'h05}
    |=> reg_rdata_o[6:5] == 2'h0) else $error("reserved bits read one");
  set_all_a: assert property (wr_ok && reg_addr_i == 6'h04 && reg_wdata_i == 8'hFF
    ##1 !wr_ok ##1 rd4
    |=> reg_rdata_o[6:0] == 7'h7F) else $error("comm set write lost");
  error_flag_a: assert property (ce_i && error_bits_i != 8'h00 ##1 rd4 |=> reg_rdata_o[1])
    else $error("error flag not set");
  tx_flag_a: assert property (ce_i && tx_last_bit_i ##1 rd4 |=> reg_rdata_o[6])
    else $error("transmit flag not set");
  timer_flag_a: assert property (ce_i && countdown_zero_i ##1 rd4 |=> reg_rdata_o[0])
    else $error("timer flag not set");
  cover property (pp_r && irq_pin_oe_o && irq_pin_o);
  cover property (rd4 ##1 reg_rdata_o[6]);
  cover property (irq_status_o);
endmodule : irqre_top_props
bind irqre_top irqre_top_props u_props (.*);

// ==== tb/irq_request_enable_logic_tb.sv ====
// Self-checking bench for the interrupt request and enable logic
`timescale 1ns/1ps
`include "irqre_consts.svh"
module irq_request_enable_logic_tb;
  logic sys_clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
  logic [5:0] reg_addr_i = 6'h00;
  logic [7:0] reg_wdata_i = 8'h00, error_bits_i = 8'h00, reg_rdata_o;
  logic tx_last_bit_i = 1'h0, rx_end_valid_i = 1'h0, receive_requires_data_option_i = 1'h0;
  logic fifo_has_data_i = 1'h0, fifo_high_status_i = 1'h0, fifo_low_status_i = 1'h0;
  logic countdown_zero_i = 1'h0, host_cmd_wr_i = 1'h0, checksum_cmd_active_i = 1'h0;
  logic checksum_all_done_i = 1'h0, mode_found_i = 1'h0, rf_reset_i = 1'h0;
  logic secure_signal_input_i = 1'h0, field_present_i = 1'h0;
  logic [3:0] cmd_code_i = 4'h0, host_cmd_code_i = 4'h0;
  logic cmd_revert_idle_o, mode_detect_run_o, irq_status_o, irq_pin_o, irq_pin_oe_o, irq_wire;
  logic [7:0] bits [6] = '{8'h40, 8'h20, 8'h01, 8'h02, 8'h08, 8'h04};
  logic [15:0] known_cmds = `IRQRE_CMD_KNOWN;
  int failures = 0;
  int checked = 0;
  irqre_top DUT (.*);
  irqre_host_model HOST (.pin_i(irq_pin_o), .oe_i(irq_pin_oe_o), .wire_o(irq_wire));
  always #2.5 sys_clk_i = ~sys_clk_i;
  task automatic final_report();
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : step
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'h1;
    step(1);
    reg_wr_i = 1'h0;
    step(1);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    reg_addr_i = a;
    reg_rd_i = 1'h1;
    step(1);
    reg_rd_i = 1'h0;
    chk("rdata", reg_rdata_o, e);
    step(1);
  endtask : rd
  task automatic ev(input int k);
    for (int v = 1; v >= 0; v--) begin
      case (k)
        0: tx_last_bit_i = v[0];
        1: rx_end_valid_i = v[0];
        2: countdown_zero_i = v[0];
        3: error_bits_i = {v[0], 7'h00};
        4: fifo_high_status_i = v[0];
        default: fifo_low_status_i = v[0];
      endcase
      if (v == 1) step(1);
    end
  endtask : ev
  task automatic stat(input logic s);
    chk("status", {7'h00, irq_status_o}, {7'h00, s});
  endtask : stat
  initial begin
    #100000;
    failures++;
    final_report();
  end
  initial begin
    step(2);
    rst_i = 1'h0;
    rd(6'h02, 8'h80);
    rd(6'h03, 8'h00);
    rd(6'h04, 8'h14);
    rd(6'h05, 8'h00);
    rd(6'h3F, 8'h00);
    chk("wire", {7'h00, irq_wire}, 8'h01);
    wr(6'h04, 8'h7F);
    rd(6'h04, 8'h00);
    for (int k = 0; k < 6; k++) begin
      ev(k);
      rd(6'h04, bits[k]);
      wr(6'h04, 8'h7F);
    end
    receive_requires_data_option_i = 1'h1;
    ev(1);
    rd(6'h04, 8'h00);
    fifo_has_data_i = 1'h1;
    ev(1);
    rd(6'h04, 8'h20);
    cmd_code_i = 4'hC;
    step(1);
    cmd_code_i = 4'h0;
    step(2);
    rd(6'h04, 8'h30);
    wr(6'h04, 8'h7F);
    cmd_code_i = 4'hC;
    step(1);
    cmd_code_i = 4'h0;
    host_cmd_wr_i = 1'h1;
    step(1);
    host_cmd_wr_i = 1'h0;
    step(2);
    rd(6'h04, 8'h00);
    for (int e = 1; e >= 0; e--) begin
      secure_signal_input_i = e[0];
      field_present_i = e[0];
      step(6);
      rd(6'h05, {3'h0, 1'h1, 2'h0, e[0], !e[0]});
      wr(6'h05, 8'h1F);
    end
    checksum_cmd_active_i = 1'h1;
    checksum_all_done_i = 1'h1;
    step(1);
    checksum_cmd_active_i = 1'h0;
    rd(6'h05, 8'h04);
    rf_reset_i = 1'h1;
    step(1);
    rf_reset_i = 1'h0;
    step(1);
    chk("run", {7'h00, mode_detect_run_o}, 8'h01);
    mode_found_i = 1'h1;
    step(1);
    mode_found_i = 1'h0;
    step(1);
    chk("run", {7'h00, mode_detect_run_o}, 8'h00);
    rd(6'h05, 8'h0C);
    for (int c = 0; c < 16; c++) begin
      host_cmd_code_i = c[3:0];
      host_cmd_wr_i = 1'h1;
      #1;
      chk("revert", {7'h00, cmd_revert_idle_o}, {7'h00, ~known_cmds[c]});
      step(1);
    end
    host_cmd_wr_i = 1'h0;
    chk("run", {7'h00, mode_detect_run_o}, 8'h01);
    rd(6'h04, {3'h0, |(~known_cmds), 4'h0});
    wr(6'h05, 8'h9F);
    for (int i = 0; i < 5; i++) begin
      wr(6'h03, 8'h01 << i);
      stat(1'h1);
    end
    wr(6'h03, 8'h60);
    stat(1'h0);
    chk("wire", {7'h00, irq_wire}, 8'h01);
    wr(6'h03, 8'h81);
    chk("wire", {7'h00, irq_wire}, 8'h00);
    wr(6'h02, 8'h00);
    chk("pin", {6'h00, irq_pin_oe_o, irq_pin_o}, 8'h03);
    wr(6'h03, 8'h00);
    wr(6'h05, 8'h1F);
    wr(6'h04, 8'hFF);
    rd(6'h04, 8'h7F);
    for (int i = 0; i < 7; i++) begin
      wr(6'h02, 8'h01 << i);
      stat(1'h1);
    end
    wr(6'h04, 8'h7F);
    stat(1'h0);
    ce_i = 1'h0;
    wr(6'h04, 8'hFF);
    ev(0);
    ce_i = 1'h1;
    rd(6'h04, 8'h00);
    stat(1'h0);
    final_report();
  end
endmodule : irq_request_enable_logic_tb
